// ### rtl/sah_handler.sv
// Station address service and parameter telegram evaluation with register port.
// Functional notes
// - Zero buffer pointer disables address service
// - Store payload, swap buffers, record length
// - Raise event, adopt address and lock
// - Release read at 14h rearms service
// - Release read returns all zeros
// - Bad address telegrams dropped silently
// - Address buffer byte layout fixed
// - Evaluate seven or eight parameter bytes
// - Parameter telegram byte layout fixed
// - Spec bit 7 enables extensions
// - Spec bit 6 enables failsafe
// - Spec bit 5 enables publisher
// - Spec bit 2 selects 1/10 ms base
// - Spec bit 1 disables stop check
// - Spec bit 0 disables start check
// - Monitoring time is base times factors
module sah_handler (
    input  wire logic                 mclk_i,
    input  wire logic                 srst_i,
    input  wire sah_pkg::sah_bus_type bus_i,
    output logic [7:0]                rdata_o,
    input  wire sah_pkg::sah_rx_type  rx_i,
    output logic                      new_address_event_o,
    output sah_pkg::sah_cfg_type      cfg_o,
    output logic [39:0]               wd_time_cycles_o,
    output logic [7:0]                station_number_o
);
    import sah_pkg::*;

    // Two physical pages; the one in use by the receiver is the auxiliary one.
    logic [7:0]  mem [2][BUF_DEPTH];
    logic        aux_sel;
    logic [7:0]  address_buffer_pointer;
    logic [7:0]  station_number_cell;
    logic [7:0]  lock_flag;
    logic [7:0]  address_payload_length;
    logic [7:0]  prm_len;
    logic        buf_busy;
    logic        new_address_event;
    logic [7:0]  wd_f1;
    logic [7:0]  wd_f2;
    logic [7:0]  min_delay;
    logic [7:0]  group_id;
    logic [7:0]  spec;
    logic [7:0]  cnt;
    logic        ovf;
    logic [7:0]  p1;
    logic [7:0]  p2;
    logic [7:0]  p3;
    logic [7:0]  p6;
    logic [7:0]  p7;
    logic [7:0]  rdata;

    logic [7:0]  next_address_buffer_pointer;
    logic [7:0]  next_station_number_cell;
    logic [7:0]  next_lock_flag;
    logic [7:0]  next_address_payload_length;
    logic [7:0]  next_prm_len;
    logic        next_buf_busy;
    logic        next_aux_sel;
    logic        next_new_address_event;
    logic [7:0]  next_wd_f1;
    logic [7:0]  next_wd_f2;
    logic [7:0]  next_min_delay;
    logic [7:0]  next_group_id;
    logic [7:0]  next_spec;
    logic [7:0]  next_cnt;
    logic        next_ovf;
    logic [7:0]  next_p1;
    logic [7:0]  next_p2;
    logic [7:0]  next_p3;
    logic [7:0]  next_p6;
    logic [7:0]  next_p7;
    logic [7:0]  next_rdata;

    logic        addr_enabled;
    logic        accept_addr;
    logic        release_rd;
    logic        frame_ok;
    logic [7:0]  byte_idx;
    logic        frame_over;

    assign addr_enabled = (address_buffer_pointer != BUF_PTR_RESET);
    // Address telegrams are taken only while the service is on and the buffer is free.
    assign accept_addr  = rx_i.is_addr && addr_enabled && !buf_busy;
    assign release_rd   = bus_i.rd && (bus_i.addr == REG_RELEASE);
    // Short or erroneous frames are simply dropped; no host action is needed.
    assign frame_ok     = rx_i.valid && rx_i.eop && !rx_i.err && !frame_over;
    // A start byte always lands at index zero, whatever the counter kept from the last frame.
    assign byte_idx     = rx_i.sop ? 8'h00 : cnt;
    assign frame_over   = (ovf && !rx_i.sop) || (byte_idx >= 8'(BUF_DEPTH));

    // Payload bytes land in the auxiliary page; overflow poisons the frame.
    always_ff @(posedge mclk_i)
    begin
        if (rx_i.valid && !frame_over && (!rx_i.is_addr || accept_addr))
        begin
            mem[aux_sel][byte_idx] <= rx_i.data;
        end
    end

    always_comb
    begin
        next_cnt = cnt;
        next_ovf = ovf;
        next_p1  = p1;
        next_p2  = p2;
        next_p3  = p3;
        next_p6  = p6;
        next_p7  = p7;
        if (rx_i.valid)
        begin
            if (rx_i.sop)
            begin
                next_cnt = 8'h00;
                next_ovf = 1'b0;
            end
            if (next_cnt >= 8'(BUF_DEPTH))
            begin
                next_ovf = 1'b1;
            end
            // Parameter header bytes are captured on the fly.
            if (!rx_i.is_addr)
            begin
                case (next_cnt)
                    8'(BYTE_WD_FACT1):  next_p1 = rx_i.data;
                    8'(BYTE_WD_FACT2):  next_p2 = rx_i.data;
                    8'(BYTE_MIN_DELAY): next_p3 = rx_i.data;
                    8'(BYTE_GROUP):     next_p6 = rx_i.data;
                    8'(BYTE_SPEC):      next_p7 = rx_i.data;
                    default:            next_p1 = next_p1;
                endcase
            end
            next_cnt = next_cnt + 8'h01;
            if (rx_i.eop)
            begin
                next_ovf = 1'b0;
            end
        end
    end

    always_comb
    begin
        next_address_buffer_pointer = address_buffer_pointer;
        next_station_number_cell    = station_number_cell;
        next_lock_flag              = lock_flag;
        next_address_payload_length = address_payload_length;
        next_prm_len                = prm_len;
        next_buf_busy               = buf_busy;
        next_aux_sel                = aux_sel;
        next_new_address_event      = 1'b0;
        next_wd_f1                  = wd_f1;
        next_wd_f2                  = wd_f2;
        next_min_delay              = min_delay;
        next_group_id               = group_id;
        next_spec                   = spec;
        if (release_rd)
        begin
            next_buf_busy = 1'b0;
        end
        if (bus_i.wr)
        begin
            case (bus_i.addr)
                REG_BUF_PTR: next_address_buffer_pointer = bus_i.wdata;
                REG_STATION: next_station_number_cell    = bus_i.wdata;
                REG_LOCK:    next_lock_flag              = bus_i.wdata;
                default:     next_lock_flag              = next_lock_flag;
            endcase
        end
        if (frame_ok && rx_i.is_addr && accept_addr && (next_cnt >= 8'(ADDR_MIN_LEN)))
        begin
            next_aux_sel                = !aux_sel;
            next_address_payload_length = next_cnt;
            next_buf_busy               = 1'b1;
            next_new_address_event      = 1'b1;
            next_station_number_cell    = mem[aux_sel][BYTE_NEW_ADDR];
            next_lock_flag              = (next_cnt == 8'(ADDR_MIN_LEN)) ?
                                          rx_i.data : mem[aux_sel][BYTE_LOCK];
            if (next_cnt == 8'h01)
            begin
                next_station_number_cell = rx_i.data;
            end
        end
        if (frame_ok && !rx_i.is_addr && (next_cnt >= 8'(PRM_BASE_LEN)))
        begin
            next_prm_len   = next_cnt;
            next_wd_f1     = next_p1;
            next_wd_f2     = next_p2;
            next_min_delay = next_p3;
            next_group_id  = next_p6;
            // The chip byte is only looked at when an eighth byte exists.
            next_spec      = (next_cnt > 8'(PRM_BASE_LEN)) ? next_p7 : SPEC_RESET;
        end
    end

    always_comb
    begin
        next_rdata = 8'h00;
        if (bus_i.rd)
        begin
            case (bus_i.addr)
                REG_BUF_PTR:      next_rdata = address_buffer_pointer;
                REG_STATION:      next_rdata = station_number_cell;
                REG_LOCK:         next_rdata = lock_flag;
                REG_RELEASE:      next_rdata = 8'h00;
                REG_PAYLOAD_LEN:  next_rdata = address_payload_length;
                REG_STATUS:       next_rdata = {6'h00, buf_busy, addr_enabled};
                REG_PRM_FLAGS:    next_rdata = spec;
                REG_WD_FACT1:     next_rdata = wd_f1;
                REG_WD_FACT2:     next_rdata = wd_f2;
                REG_WD_CYCLES_LO: next_rdata = wd_time_cycles_o[7:0];
                REG_WD_CYCLES_HI: next_rdata = wd_time_cycles_o[15:8];
                REG_MIN_DELAY:    next_rdata = min_delay;
                REG_GROUP:        next_rdata = group_id;
                REG_PRM_LEN:      next_rdata = prm_len;
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            address_buffer_pointer <= BUF_PTR_RESET;
            station_number_cell    <= STATION_RESET;
            lock_flag              <= 8'h00;
            address_payload_length <= 8'h00;
            prm_len                <= 8'h00;
            buf_busy               <= 1'b0;
            aux_sel                <= 1'b0;
            new_address_event      <= 1'b0;
            wd_f1                  <= 8'h00;
            wd_f2                  <= 8'h00;
            min_delay              <= 8'h00;
            group_id               <= 8'h00;
            spec                   <= SPEC_RESET;
            cnt                    <= 8'h00;
            ovf                    <= 1'b0;
            p1                     <= 8'h00;
            p2                     <= 8'h00;
            p3                     <= 8'h00;
            p6                     <= 8'h00;
            p7                     <= 8'h00;
            rdata                  <= 8'h00;
        end
        else
        begin
            address_buffer_pointer <= next_address_buffer_pointer;
            station_number_cell    <= next_station_number_cell;
            lock_flag              <= next_lock_flag;
            address_payload_length <= next_address_payload_length;
            prm_len                <= next_prm_len;
            buf_busy               <= next_buf_busy;
            aux_sel                <= next_aux_sel;
            new_address_event      <= next_new_address_event;
            wd_f1                  <= next_wd_f1;
            wd_f2                  <= next_wd_f2;
            min_delay              <= next_min_delay;
            group_id               <= next_group_id;
            spec                   <= next_spec;
            cnt                    <= next_cnt;
            ovf                    <= next_ovf;
            p1                     <= next_p1;
            p2                     <= next_p2;
            p3                     <= next_p3;
            p6                     <= next_p6;
            p7                     <= next_p7;
            rdata                  <= next_rdata;
        end
    end

    assign rdata_o             = rdata;
    assign new_address_event_o = new_address_event;
    assign station_number_o    = station_number_cell;
    assign cfg_o.ext_on        = spec[BIT_EXT_ON];
    assign cfg_o.failsafe      = spec[BIT_FAILSAFE];
    assign cfg_o.publisher     = spec[BIT_PUBLISHER];
    assign cfg_o.watchdog_time_base_fast  = spec[BIT_WATCHDOG_TIME_BASE];
    assign cfg_o.no_stop_chk   = spec[BIT_NO_STOP_CHK];
    assign cfg_o.no_start_chk  = spec[BIT_NO_START_CHK];
    // The worst case, 255*255 slow ticks, is about 1.6e11 cycles, so 32 bits are not enough.
    assign wd_time_cycles_o    = 40'(wd_f1) * 40'(wd_f2) *
                                 40'(spec[BIT_WATCHDOG_TIME_BASE] ? FAST_TICK_CYCLES : SLOW_TICK_CYCLES);

    chk_release_zero: assert property (@(posedge mclk_i) disable iff (srst_i)
        release_rd |=> (rdata_o == 8'h00)) else $error("release read not zero");
    chk_disabled_idle: assert property (@(posedge mclk_i) disable iff (srst_i)
        !addr_enabled |=> !new_address_event_o) else $error("event while disabled");
    chk_busy_blocks: assert property (@(posedge mclk_i) disable iff (srst_i)
        (buf_busy && !release_rd) |=> !new_address_event_o) else $error("event while busy");
    chk_event_sets_busy: assert property (@(posedge mclk_i) disable iff (srst_i)
        new_address_event_o |-> buf_busy) else $error("event without busy");
    chk_release_frees: assert property (@(posedge mclk_i) disable iff (srst_i)
        (release_rd && !(frame_ok && accept_addr)) |=> !buf_busy) else $error("release ignored");
    chk_swap_page: assert property (@(posedge mclk_i) disable iff (srst_i)
        new_address_event_o |-> (aux_sel != $past(aux_sel))) else $error("no buffer swap");
    chk_base_select: assert property (@(posedge mclk_i) disable iff (srst_i)
        (wd_f1 == 8'h01 && wd_f2 == 8'h01 && cfg_o.watchdog_time_base_fast) |->
        (wd_time_cycles_o == 40'(FAST_TICK_CYCLES))) else $error("wrong time base");
    chk_short_prm: assert property (@(posedge mclk_i) disable iff (srst_i)
        (frame_ok && !rx_i.is_addr && next_cnt == 8'(PRM_BASE_LEN)) |=> (spec == SPEC_RESET))
        else $error("chip byte taken from short frame");
endmodule

// ### rtl/sah_pkg.sv
// Shared constants and carrier types for the station address and parameter handler.
package sah_pkg;
    localparam int          ADDR_W              = 8;
    localparam int          DATA_W              = 8;
    localparam logic [7:0]  REG_BUF_PTR         = 8'h13;
    localparam logic [7:0]  REG_STATION         = 8'h15;
    localparam logic [7:0]  REG_LOCK            = 8'h16;
    localparam logic [7:0]  REG_RELEASE         = 8'h14;
    localparam logic [7:0]  REG_PAYLOAD_LEN     = 8'h17;
    localparam logic [7:0]  REG_STATUS          = 8'h18;
    localparam logic [7:0]  REG_PRM_FLAGS       = 8'h19;
    localparam logic [7:0]  REG_WD_FACT1        = 8'h1A;
    localparam logic [7:0]  REG_WD_FACT2        = 8'h1B;
    localparam logic [7:0]  REG_WD_CYCLES_LO    = 8'h1C;
    localparam logic [7:0]  REG_WD_CYCLES_HI    = 8'h1D;
    localparam logic [7:0]  REG_MIN_DELAY       = 8'h1E;
    localparam logic [7:0]  REG_GROUP           = 8'h1F;
    localparam logic [7:0]  REG_PRM_LEN         = 8'h20;
    localparam logic [7:0]  BUF_PTR_RESET       = 8'h00;
    localparam logic [7:0]  STATION_RESET       = 8'h7E;
    localparam logic [7:0]  LOCK_TRUE           = 8'hFF;
    localparam int          BYTE_NEW_ADDR       = 0;
    localparam int          BYTE_LOCK           = 3;
    localparam int          BYTE_WD_FACT1       = 1;
    localparam int          BYTE_WD_FACT2       = 2;
    localparam int          BYTE_MIN_DELAY      = 3;
    localparam int          BYTE_GROUP          = 6;
    localparam int          BYTE_SPEC           = 7;
    localparam int          PRM_BASE_LEN        = 7;
    localparam int          ADDR_MIN_LEN        = 4;
    localparam int          BUF_DEPTH           = 244;
    localparam int          BIT_EXT_ON          = 7;
    localparam int          BIT_FAILSAFE        = 6;
    localparam int          BIT_PUBLISHER       = 5;
    localparam int          BIT_WATCHDOG_TIME_BASE         = 2;
    localparam int          BIT_NO_STOP_CHK     = 1;
    localparam int          BIT_NO_START_CHK    = 0;
    localparam logic [7:0]  SPEC_RESET          = 8'h00;
    localparam int          WATCHDOG_TIME_BASE_SLOW_MS     = 10;
    localparam int          WATCHDOG_TIME_BASE_FAST_MS     = 1;
    localparam int          CLK_MHZ             = 250;
    localparam logic [31:0] SLOW_TICK_CYCLES    = 32'(WATCHDOG_TIME_BASE_SLOW_MS * CLK_MHZ * 1000);
    localparam logic [31:0] FAST_TICK_CYCLES    = 32'(WATCHDOG_TIME_BASE_FAST_MS * CLK_MHZ * 1000);

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sah_bus_type;

    typedef struct packed {
        logic       valid;
        logic       sop;
        logic       eop;
        logic       err;
        logic       is_addr;
        logic [7:0] data;
    } sah_rx_type;

    typedef struct packed {
        logic ext_on;
        logic failsafe;
        logic publisher;
        logic watchdog_time_base_fast;
        logic no_stop_chk;
        logic no_start_chk;
    } sah_cfg_type;
endpackage

// ### sim/sah_master_model.sv
// Behavioural fieldbus master that hands service telegram bytes to the handler.
module sah_master_model (
    input  wire logic         mclk_i,
    output sah_pkg::sah_rx_type rx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import sah_pkg::*;

    initial rx_o = '0;

    // Bytes go out contiguous from start to end marker; the error flag rides on the last byte.
    // Callers keep chip byte bits 4 and 3 at zero and send at most eight bytes per telegram.
    // The n bytes sit in the low end of b with the first byte highest, so b[7:0] goes last.
    task automatic send(input logic [63:0] b, input int n, input logic is_addr, input logic bad);
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk_i);
            rx_o <= '{1'b1, i == 0, i == n - 1, bad && (i == n - 1), is_addr, b[8*(n-1-i) +: 8]};
        end
        @(posedge mclk_i);
        // An idle line shows the inverse byte so a stale value can never pass as data.
        rx_o <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ~b[7:0]};
    endtask
endmodule

// ### sim/tb.sv
// Self-checking testbench for the station address and parameter handler.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sah_pkg::*;

    logic        mclk_i;
    logic        srst_i;
    sah_bus_type bus;
    logic [7:0]  rdata;
    sah_rx_type  rx;
    logic        evt;
    sah_cfg_type cfg;
    logic [39:0] wd_cycles;
    logic [7:0]  station;
    int          n_mismatch;
    int          tests_run;

`define CHK(act, exp, msg) begin tests_run++; if ((act) !== (exp)) begin n_mismatch++; $display("BAD t=%0t %s got %h exp %h", $time, msg, act, exp); end end

    sah_handler dut (
        .mclk_i              (mclk_i),
        .srst_i              (srst_i),
        .bus_i               (bus),
        .rdata_o             (rdata),
        .rx_i                (rx),
        .new_address_event_o (evt),
        .cfg_o               (cfg),
        .wd_time_cycles_o    (wd_cycles),
        .station_number_o    (station)
    );

    sah_master_model m (
        .mclk_i (mclk_i),
        .rx_o   (rx)
    );

    initial
    begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge mclk_i);
        bus <= '0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        @(posedge mclk_i);
        bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk_i);
        bus <= '0;
        #1;
        `CHK(rdata, exp, msg)
    endtask

    // Counts event samples over a bounded window, so a stuck or doubled pulse shows up too.
    task automatic frame(input logic [63:0] b, input int n, input logic is_addr,
                         input logic bad, output int c);
        m.send(b, n, is_addr, bad);
        c = 0;
        for (int k = 0; k < 6; k++)
        begin
            #1;
            if (evt === 1'b1)
                c++;
            @(posedge mclk_i);
        end
    endtask

    task automatic t_disabled();
        int c;
        rd_chk(REG_BUF_PTR, 8'h00, "pointer reset");
        frame(64'({8'h05, 8'h12, 8'h34, 8'hFF}), 4, 1'b1, 1'b0, c);
        `CHK(c, 0, "event while disabled")
        `CHK(station, STATION_RESET, "station while disabled")
        wr_reg(REG_STATION, 8'h22);
        @(posedge mclk_i);
        #1;
        `CHK(station, 8'h22, "host station write")
        $display("test disabled done");
    endtask

    task automatic t_accept();
        int c;
        wr_reg(REG_BUF_PTR, 8'h10);
        wr_reg(REG_LOCK, 8'h00);
        frame(64'({8'h05, 8'h12, 8'h34, LOCK_TRUE}), 4, 1'b1, 1'b0, c);
        `CHK(c, 1, "one event pulse")
        `CHK(station, 8'h05, "adopted station")
        rd_chk(REG_LOCK, LOCK_TRUE, "adopted lock");
        rd_chk(REG_PAYLOAD_LEN, 8'h04, "payload length");
        rd_chk(REG_STATUS, 8'h03, "busy and enabled");
        $display("test accept done");
    endtask

    task automatic t_release();
        int c;
        frame(64'({8'h09, 8'h12, 8'h34, 8'h00}), 4, 1'b1, 1'b0, c);
        `CHK(c, 0, "event before release")
        `CHK(station, 8'h05, "station before release")
        rd_chk(REG_RELEASE, 8'h00, "release reads zero");
        rd_chk(REG_STATUS, 8'h01, "busy cleared");
        frame(64'({8'h0A, 8'h12, 8'h34, 8'h00}), 4, 1'b1, 1'b1, c);
        `CHK(c, 0, "event on bad frame")
        frame(64'({8'h0A, 8'h12, 8'h34}), 3, 1'b1, 1'b0, c);
        `CHK(c, 0, "event on short frame")
        `CHK(station, 8'h05, "station after bad frames")
        frame(64'({8'h0B, 8'h12, 8'h34, 8'h00, 8'hAA, 8'hBB}), 6, 1'b1, 1'b0, c);
        `CHK(c, 1, "event after release")
        `CHK(station, 8'h0B, "station after release")
        rd_chk(REG_PAYLOAD_LEN, 8'h06, "long payload length");
        rd_chk(REG_LOCK, 8'h00, "lock cleared");
        $display("test release done");
    endtask

    task automatic t_param();
        logic [7:0]  spec [7] = '{8'h80, 8'h40, 8'h20, 8'h04, 8'h02, 8'h01, 8'hE7};
        logic [7:0]  f1;
        logic [7:0]  s;
        sah_cfg_type e;
        logic [39:0] wd;
        int          c;
        for (int i = 0; i < 7; i++)
        begin
            f1 = 8'(2 + i);
            s = spec[i];
            e = '{s[7], s[6], s[5], s[2], s[1], s[0]};
            wd = 40'(f1) * 40'd3 * 40'(s[2] ? FAST_TICK_CYCLES : SLOW_TICK_CYCLES);
            frame({8'h00, f1, 8'h03, 8'h0B, 8'h12, 8'h34, 8'h05, s}, 8, 1'b0, 1'b0, c);
            `CHK(cfg, e, "chip byte flags")
            `CHK(wd_cycles, wd, "monitoring time")
            rd_chk(REG_WD_FACT1, f1, "factor one");
            rd_chk(REG_GROUP, 8'h05, "group byte");
            rd_chk(REG_PRM_FLAGS, s, "chip byte");
        end
        // Unit factors are not checked by the hardware, so the bare fast base must come out.
        frame({8'h00, 8'h01, 8'h01, 8'h0B, 8'h12, 8'h34, 8'h05, 8'h04}, 8, 1'b0, 1'b0, c);
        `CHK(wd_cycles, 40'(FAST_TICK_CYCLES), "unit factors fast base")
        frame(64'({8'h00, 8'h04, 8'h05, 8'h0B, 8'h12, 8'h34, 8'h06}), 7, 1'b0, 1'b0, c);
        `CHK(cfg, sah_cfg_type'(0), "seven byte defaults")
        wd = 40'd20 * 40'(SLOW_TICK_CYCLES);
        `CHK(wd_cycles, wd, "default base")
        rd_chk(REG_WD_CYCLES_LO, wd[7:0], "monitoring time low");
        rd_chk(REG_WD_CYCLES_HI, wd[15:8], "monitoring time high");
        rd_chk(REG_MIN_DELAY, 8'h0B, "min delay byte");
        rd_chk(REG_PRM_LEN, 8'h07, "parameter length");
        rd_chk(REG_PRM_FLAGS, 8'h00, "chip byte default");
        $display("test param done");
    endtask

    // A full run needs well under a thousand cycles; this bound only cuts a hang.
    initial
    begin
        #100000;
        n_mismatch++;
        end_sim();
    end

    initial
    begin
        n_mismatch = 0;
        tests_run = 0;
        srst_i = 1'b1;
        bus = '0;
        repeat (6) @(posedge mclk_i);
        srst_i <= 1'b0;
        t_disabled();
        t_accept();
        t_release();
        t_param();
        end_sim();
    end
endmodule
